// [rtl/lsau_consts.svh]
// Constants of the link status and alarm unit
`ifndef LSAU_CONSTS_SVH
`define LSAU_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and lamp timing
// ----------------------------------------------------------------
`define LSAU_CLK_KHZ        25000
`define LSAU_LAMP_ON_MS     200
`define LSAU_LAMP_OFF_MS    200
`define LSAU_LAMP_GAP_MS    1000
`define LSAU_SYNC_FILL      2'h3

// ----------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------
`define LSAU_ADDR_CNT       12
`define LSAU_ADDR_LOW_CNT   6
`define LSAU_STAT_RSP_LSB   0
`define LSAU_STAT_REQ_LSB   16
`define LSAU_STAT_PAD       4'h0
`define LSAU_STATUS_RESET   32'h0000_0000

// ----------------------------------------------------------------
// Alarm codes and blink counts
// ----------------------------------------------------------------
`define LSAU_CODE_HEAT      8'h21
`define LSAU_BLINK_HEAT     4'h2
`define LSAU_CODE_NVDATA    8'h41
`define LSAU_BLINK_NVDATA   4'h9
`define LSAU_CODE_SWITCH    8'h83
`define LSAU_BLINK_SWITCH   4'h7
`define LSAU_CODE_LINKERR   8'h84
`define LSAU_BLINK_LINKERR  4'h7
`define LSAU_CODE_DUPADDR   8'h86
`define LSAU_BLINK_DUPADDR  4'h7
`define LSAU_RATE_REQUIRED  4'h7
`define LSAU_ERR_LIMIT      2'h3

// ----------------------------------------------------------------
// History
// ----------------------------------------------------------------
`define LSAU_HIST_DEPTH     10

`endif

// [rtl/lsau_pkg.sv]
// Types of the link status and alarm unit
package lsau_pkg;

  // Present alarm descriptor
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] blinks;
    logic       stops_link;
    logic       power_only;
  } lsau_alarm_s;

  // Lamp sequencer states
  typedef enum logic [2:0] {
    LSAU_LAMP_IDLE   = 3'b000,
    LSAU_LAMP_ON     = 3'b001,
    LSAU_LAMP_OFF    = 3'b010,
    LSAU_LAMP_GAP    = 3'b011,
    LSAU_LAMP_STEADY = 3'b100
  } lsau_lamp_e;

  // History read request
  typedef struct packed {
    logic       rd;
    logic [3:0] index;
  } lsau_hist_req_s;

endpackage

// [rtl/lsau_hist_mem.sv]
// Small alarm history memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module lsau_hist_mem
  import lsau_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 10
) (
  // Clock
  input  wire logic             clk,
  input  wire logic             clk_en,
  // Write side
  input  wire logic             wr,
  input  wire logic [3:0]       wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [3:0]       rd_addr,
  output var  logic [WIDTH-1:0] rd_data
);

  initial begin
    if (DEPTH < 1 || DEPTH > 16) begin
      $error("lsau_hist_mem: DEPTH out of range");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (clk_en && wr) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // lsau_hist_mem
`default_nettype wire

// [rtl/lsau_blink.sv]
// Blink-coded fault lamp sequencer
`timescale 1ns/100ps
`default_nettype none
module lsau_blink
  import lsau_pkg::*;
#(
  parameter int unsigned ON_CYC  = 5000000,
  parameter int unsigned OFF_CYC = 5000000,
  parameter int unsigned GAP_CYC = 25000000
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // Control
  input  wire logic       active,
  input  wire logic       steady,
  input  wire logic [3:0] blinks,
  // Lamp
  output var  logic       lamp
);

  initial begin
    if (ON_CYC < 1 || OFF_CYC < 1 || GAP_CYC < 1) begin
      $error("lsau_blink: counts must be at least one");
    end
  end

  lsau_lamp_e  state;
  lsau_lamp_e  next_state;
  logic [31:0] timer;
  logic [3:0]  done_cnt;
  wire         timer_end = (timer == 32'h0000_0001);
  wire         last_blink = (done_cnt + 4'h1 >= blinks);

  always_comb begin
    next_state = state;
    case (state)
      LSAU_LAMP_IDLE:
        if (steady) next_state = LSAU_LAMP_STEADY;
        else if (active) next_state = LSAU_LAMP_ON;
      LSAU_LAMP_ON:
        if (timer_end) next_state = LSAU_LAMP_OFF;
      LSAU_LAMP_OFF:
        if (timer_end) begin
          next_state = last_blink ? LSAU_LAMP_GAP : LSAU_LAMP_ON;
        end
      LSAU_LAMP_GAP:
        if (timer_end) next_state = LSAU_LAMP_IDLE;
      LSAU_LAMP_STEADY:
        if (!steady) next_state = LSAU_LAMP_IDLE;
      default:
        next_state = LSAU_LAMP_IDLE;
    endcase
    if (!steady && !active) next_state = LSAU_LAMP_IDLE;
    else if (steady) next_state = LSAU_LAMP_STEADY;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state    <= LSAU_LAMP_IDLE;
      timer    <= 32'h0000_0000;
      done_cnt <= 4'h0;
      lamp     <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      lamp  <= (next_state == LSAU_LAMP_ON) ||
               (next_state == LSAU_LAMP_STEADY);
      if (next_state != state) begin
        case (next_state)
          LSAU_LAMP_ON:  timer <= ON_CYC;
          LSAU_LAMP_OFF: timer <= OFF_CYC;
          LSAU_LAMP_GAP: timer <= GAP_CYC;
          default:       timer <= 32'h0000_0000;
        endcase
      end else if (timer != 32'h0000_0000) begin
        timer <= timer - 32'h0000_0001;
      end
      if (next_state == LSAU_LAMP_IDLE) done_cnt <= 4'h0;
      else if (state == LSAU_LAMP_OFF && next_state == LSAU_LAMP_ON) begin
        done_cnt <= done_cnt + 4'h1;
      end
    end
  end

endmodule // lsau_blink
`default_nettype wire

// [rtl/lsau_top.sv]
// Downstream link status word, alarm latch, history and lamp control
//
// Summary of operation
// - A status query pulse returns the link status word.
// - The status word is 32 bits wide.
// - Upper half bit m mirrors the connection enable of address m.
// - Lower half bit m is 1 only while address m exchanges correctly.
// - Bits 12 to 15 of both halves always read zero.
// - Any alarm drives the alarm flag output high.
// - Lamp blinks with the alarm's blink count from the clock after the flag rises.
// - Ten newest alarm records kept, read newest first, clearable.
// - Alarm reset command clears resettable alarms; reset clears all.
// - Power-only alarms ignore the reset command; no reset while lamp is steady.
// - Overheat gives code 21h, two blinks; link keeps running.
// - Damaged stored settings give code 41h, nine blinks.
// - Rate switch not equal to 7 gives code 83h, seven blinks.
// - Three consecutive link errors give 84h, stop link, power-only.
// - Duplicate address fault gives 86h, handled as link stopping.
// - Stopped link refuses parameter, maintenance and monitor forwarding.
// - Addresses 6 to 11 serviced only in twelve-axis mode.
`include "lsau_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module lsau_top
  import lsau_pkg::*;
#(
  parameter int ADDR_CNT   = `LSAU_ADDR_CNT,
  parameter int HIST_DEPTH = `LSAU_HIST_DEPTH,
  parameter int unsigned LAMP_ON_CYC  = `LSAU_LAMP_ON_MS * `LSAU_CLK_KHZ,
  parameter int unsigned LAMP_OFF_CYC = `LSAU_LAMP_OFF_MS * `LSAU_CLK_KHZ,
  parameter int unsigned LAMP_GAP_CYC = `LSAU_LAMP_GAP_MS * `LSAU_CLK_KHZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Configuration and pins
  input  wire logic [11:0] conn_enable,
  input  wire logic        twelve_axis_pin,
  input  wire logic [3:0]  rate_select_switch,
  input  wire logic        overheat_pin,
  // Fault events from the link and storage logic
  input  wire logic        xchg_done,
  input  wire logic [3:0]  xchg_addr,
  input  wire logic        xchg_ok,
  input  wire logic        dup_addr_fault,
  input  wire logic        nv_data_bad,
  input  wire logic        steady_fault,
  // Host commands
  input  wire logic        status_query,
  input  wire logic        alarm_reset_cmd,
  input  wire logic        hist_clear,
  input  wire lsau_hist_req_s hist_req,
  input  wire logic        fwd_req,
  // Answers
  output var  logic [31:0] status_word,
  output var  logic        status_valid,
  output var  logic [7:0]  hist_code,
  output var  logic        hist_present,
  output var  logic        hist_valid,
  output logic             fwd_grant,
  output logic             fwd_refuse,
  // Alarm outputs
  output var  logic        alarm_flag_output,
  output var  logic [7:0]  alarm_code,
  output var  logic        link_stop,
  output var  logic        twelve_axis_mode,
  output logic             fault_blink_lamp
);

  initial begin
    if (ADDR_CNT != `LSAU_ADDR_CNT) begin
      $error("lsau_top: status word holds exactly twelve addresses");
    end
    if (HIST_DEPTH < 1 || HIST_DEPTH > 16) begin
      $error("lsau_top: HIST_DEPTH out of range");
    end
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic lsau_alarm_s make_alarm(input logic [7:0] code,
                                             input logic [3:0] blinks,
                                             input logic       stop);
    lsau_alarm_s a;
    a.code       = code;
    a.blinks     = blinks;
    a.stops_link = stop;
    a.power_only = stop;
    return a;
  endfunction

  function automatic logic [3:0] hist_wrap(input logic [4:0] v);
    logic [4:0] d;
    d = v;
    if (d >= 5'(HIST_DEPTH)) d = d - 5'(HIST_DEPTH);
    return d[3:0];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers, change taken when stages two and three agree
  // ----------------------------------------------------------------
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;
  logic [5:0] pin_f;
  wire  [5:0] pin_raw = {twelve_axis_pin, overheat_pin, rate_select_switch};

  always_ff @(posedge clk) begin
    if (reset) begin
      // Stages start at the filter's idle value, no false change
      pin_s1 <= 6'h07;
      pin_s2 <= 6'h07;
      pin_s3 <= 6'h07;
      pin_f  <= 6'h07;
    end else if (clk_en) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 6; i++) begin
        if (pin_s2[i] == pin_s3[i]) pin_f[i] <= pin_s3[i];
      end
    end
  end

  wire [3:0] rate_f     = pin_f[3:0];
  wire       overheat_f = pin_f[4];

  // Mode pin read once, when all stages hold real pin samples
  logic       mode_taken;
  logic [1:0] fill;
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_taken       <= 1'b0;
      fill             <= 2'h0;
      twelve_axis_mode <= 1'b0;
    end else if (clk_en) begin
      if (fill != `LSAU_SYNC_FILL) fill <= fill + 2'h1;
      if (!mode_taken && fill == `LSAU_SYNC_FILL &&
          pin_s3[5] == pin_s2[5]) begin
        twelve_axis_mode <= pin_s3[5];
        mode_taken       <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic [11:0] rsp_bits;
  wire  [11:0] addr_serviced = twelve_axis_mode ? 12'hFFF : 12'h03F;
  wire  [11:0] live_rsp = rsp_bits & conn_enable & addr_serviced;
  wire  [31:0] status_now = {`LSAU_STAT_PAD, conn_enable,
                             `LSAU_STAT_PAD, live_rsp};
  wire         xchg_in_range = (xchg_addr < 4'(ADDR_CNT)) &&
                               addr_serviced[xchg_addr];

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_bits <= 12'h000;
    end else if (clk_en) begin
      if (link_stop) begin
        rsp_bits <= 12'h000;
      end else if (xchg_done && xchg_in_range) begin
        rsp_bits[xchg_addr] <= xchg_ok;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status_word  <= `LSAU_STATUS_RESET;
      status_valid <= 1'b0;
    end else if (clk_en) begin
      status_valid <= status_query;
      if (status_query) status_word <= status_now;
    end
  end

  // ----------------------------------------------------------------
  // Consecutive link error counter
  // ----------------------------------------------------------------
  logic [1:0] err_run;
  wire        xchg_bad = xchg_done && xchg_in_range && !xchg_ok;
  always_ff @(posedge clk) begin
    if (reset) begin
      err_run <= 2'h0;
    end else if (clk_en && xchg_done && xchg_in_range) begin
      if (xchg_ok) err_run <= 2'h0;
      else if (err_run != `LSAU_ERR_LIMIT) err_run <= err_run + 2'h1;
    end
  end
  wire linkerr_hit = xchg_bad && (err_run == `LSAU_ERR_LIMIT - 2'h1);

  // ----------------------------------------------------------------
  // Alarm source selection, fixed priority
  // ----------------------------------------------------------------
  wire heat_hit   = overheat_f;
  wire switch_hit = mode_taken && (rate_f != `LSAU_RATE_REQUIRED);
  wire any_hit    = heat_hit | nv_data_bad | switch_hit |
                    linkerr_hit | dup_addr_fault;
  lsau_alarm_s new_alarm;
  always_comb begin
    if (linkerr_hit) begin
      new_alarm = make_alarm(`LSAU_CODE_LINKERR, `LSAU_BLINK_LINKERR,
                             1'b1);
    end else if (dup_addr_fault) begin
      new_alarm = make_alarm(`LSAU_CODE_DUPADDR, `LSAU_BLINK_DUPADDR,
                             1'b1);
    end else if (nv_data_bad) begin
      new_alarm = make_alarm(`LSAU_CODE_NVDATA, `LSAU_BLINK_NVDATA,
                             1'b1);
    end else if (switch_hit) begin
      new_alarm = make_alarm(`LSAU_CODE_SWITCH, `LSAU_BLINK_SWITCH,
                             1'b1);
    end else begin
      new_alarm = make_alarm(`LSAU_CODE_HEAT, `LSAU_BLINK_HEAT,
                             1'b0);
    end
  end

  // ----------------------------------------------------------------
  // Present alarm latch
  // ----------------------------------------------------------------
  lsau_alarm_s cur_alarm;
  wire reset_ok = alarm_reset_cmd && alarm_flag_output &&
                  !cur_alarm.power_only && !steady_fault;
  wire raise    = any_hit && (!alarm_flag_output || reset_ok);

  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_flag_output <= 1'b0;
      cur_alarm         <= '0;
      alarm_code        <= 8'h00;
      link_stop         <= 1'b0;
    end else if (clk_en) begin
      if (raise) begin
        alarm_flag_output <= 1'b1;
        cur_alarm         <= new_alarm;
        alarm_code        <= new_alarm.code;
        link_stop         <= new_alarm.stops_link;
      end else if (reset_ok) begin
        alarm_flag_output <= 1'b0;
        cur_alarm         <= '0;
        alarm_code        <= 8'h00;
        link_stop         <= 1'b0;
      end
    end
  end

  // Forwarding to downstream products is gated by the link stop
  assign fwd_grant  = fwd_req && !link_stop;
  assign fwd_refuse = fwd_req && link_stop;

  // ----------------------------------------------------------------
  // Alarm history, newest first
  // ----------------------------------------------------------------
  logic [3:0] hist_wp;
  logic [4:0] hist_cnt;
  wire        hist_wr    = raise && clk_en;
  wire  [3:0] newest     = hist_wrap(5'(hist_wp) + 5'(HIST_DEPTH) - 5'h01);
  wire  [3:0] hist_rd_ad = hist_wrap(5'(newest) + 5'(HIST_DEPTH) -
                                     5'(hist_req.index));
  wire        idx_ok     = 5'(hist_req.index) < hist_cnt;

  always_ff @(posedge clk) begin
    if (reset) begin
      hist_wp      <= 4'h0;
      hist_cnt     <= 5'h00;
      hist_valid   <= 1'b0;
      hist_present <= 1'b0;
    end else if (clk_en) begin
      hist_valid <= hist_req.rd;
      if (hist_req.rd) hist_present <= idx_ok;
      if (hist_wr) begin
        hist_wp <= hist_wrap(5'(hist_wp) + 5'h01);
      end
      if (hist_wr) begin
        if (hist_cnt != 5'(HIST_DEPTH)) hist_cnt <= hist_cnt + 5'h01;
      end else if (hist_clear) begin
        hist_cnt <= 5'h00;
      end
    end
  end

  lsau_hist_mem #(
    .WIDTH (8),
    .DEPTH (HIST_DEPTH)
  ) u_hist (
    .clk     (clk),
    .clk_en  (clk_en),
    .wr      (hist_wr),
    .wr_addr (hist_wp),
    .wr_data (new_alarm.code),
    .rd_addr (hist_rd_ad),
    .rd_data (hist_code)
  );

  // ----------------------------------------------------------------
  // Fault lamp
  // ----------------------------------------------------------------
  lsau_blink #(
    .ON_CYC  (LAMP_ON_CYC),
    .OFF_CYC (LAMP_OFF_CYC),
    .GAP_CYC (LAMP_GAP_CYC)
  ) u_blink (
    .clk    (clk),
    .reset  (reset),
    .clk_en (clk_en),
    .active (alarm_flag_output),
    .steady (steady_fault),
    .blinks (cur_alarm.blinks),
    .lamp   (fault_blink_lamp)
  );

endmodule // lsau_top
`default_nettype wire

// [verification/lsau_props.sv]
// Port checker of the link status and alarm unit
`timescale 1ns/100ps
`default_nettype none
module lsau_props
  import lsau_pkg::*;
(
  // Clock and reset
  input wire logic           clk,
  input wire logic           reset,
  input wire logic           clk_en,
  // Stimulus
  input wire logic [11:0]    conn_enable,
  input wire logic           nv_data_bad,
  input wire logic           dup_addr_fault,
  input wire logic           xchg_done,
  input wire logic           xchg_ok,
  input wire logic           steady_fault,
  input wire logic           status_query,
  input wire logic           alarm_reset_cmd,
  input wire lsau_hist_req_s hist_req,
  input wire logic           fwd_req,
  // Answers
  input wire logic [31:0]    status_word,
  input wire logic           status_valid,
  input wire logic           hist_valid,
  input wire logic           fwd_grant,
  input wire logic           fwd_refuse,
  input wire logic           alarm_flag_output,
  input wire logic [7:0]     alarm_code,
  input wire logic           link_stop,
  input wire logic           fault_blink_lamp
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset || !clk_en);

  a_query_answer: assert property (
    status_query |=> status_valid) else $error("query not answered");
  a_valid_cause: assert property (
    status_valid |-> $past(status_query)) else $error("stray status valid");
  a_pad_zero: assert property (
    status_valid |-> status_word[31:28] == 4'h0 && status_word[15:12] == 4'h0)
    else $error("status pad bits set");
  a_upper_cfg: assert property (
    status_query |=> status_word[27:16] == $past(conn_enable))
    else $error("upper half differs from connection setting");
  a_lower_sub: assert property (
    status_valid |-> (status_word[11:0] & ~status_word[27:16]) == 12'h000)
    else $error("response bit for disabled address");
  a_flag_code: assert property (
    alarm_flag_output == (alarm_code != 8'h00)) else $error("flag and code");
  a_nv_raise: assert property (
    nv_data_bad && !alarm_flag_output && !dup_addr_fault
      && !(xchg_done && !xchg_ok)
    |=> alarm_code == 8'h41 && link_stop) else $error("stored data alarm");
  a_lamp_start: assert property (
    $rose(alarm_flag_output) |=> fault_blink_lamp) else $error("lamp late");
  a_fwd_gate: assert property (
    fwd_grant == (fwd_req && !link_stop) && fwd_refuse == (fwd_req && link_stop))
    else $error("forward gating");
  a_stop_keeps: assert property (
    alarm_flag_output && link_stop && alarm_reset_cmd
    |=> alarm_flag_output && alarm_code == $past(alarm_code))
    else $error("power only alarm was reset");
  a_steady_keeps: assert property (
    alarm_flag_output && steady_fault |=> alarm_flag_output && $stable(alarm_code))
    else $error("alarm reset while lamp steady");
  a_heat_runs: assert property (
    alarm_code == 8'h21 |-> !link_stop) else $error("overheat stopped link");
  a_hist_answer: assert property (
    hist_req.rd |=> hist_valid) else $error("history read not answered");
endmodule // lsau_props

bind lsau_top lsau_props u_props (.clk, .reset, .clk_en, .conn_enable,
  .nv_data_bad, .dup_addr_fault, .xchg_done, .xchg_ok, .steady_fault,
  .status_query, .alarm_reset_cmd, .hist_req, .fwd_req, .status_word,
  .status_valid, .hist_valid, .fwd_grant, .fwd_refuse, .alarm_flag_output,
  .alarm_code, .link_stop, .fault_blink_lamp);
`default_nettype wire

// [verification/lsau_far_model.sv]
// Downstream exchange source standing in for the drive units
`timescale 1ns/100ps
`default_nettype none
module lsau_far_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Scan control
  input  wire logic        run,
  input  wire logic [11:0] conn,
  input  wire logic [11:0] bad,
  // Exchange results
  output logic             done,
  output logic [3:0]       addr,
  output logic             ok
);
  logic [3:0] cur = 4'h0;
  logic       slot = 1'b0;
  initial addr = 4'h0;
  initial ok = 1'b0;
  always @(posedge clk) begin
    slot <= ~slot;
    if (reset || !run) begin
      cur  <= 4'h0;
      done <= 1'b0;
    end else if (slot) begin
      cur  <= (cur == 4'hB) ? 4'h0 : cur + 4'h1;
      done <= conn[cur];
    end else
      done <= 1'b0;
    // Idle result lines toggle so stale values never look valid
    addr <= (slot && run && conn[cur]) ? cur : ~addr;
    ok   <= (slot && run) ? ~bad[cur] : ~ok;
  end
endmodule // lsau_far_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench of the link status and alarm unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb
  import lsau_pkg::*;
;
  logic           clk = 1'b0, reset = 1'b1, clk_en = 1'b1, run = 1'b0;
  logic [11:0]    conn_enable = 12'h000, bad = 12'h000;
  logic           twelve_axis_pin = 1'b0, overheat_pin = 1'b0;
  logic [3:0]     rate_select_switch = 4'h7;
  logic           dup_addr_fault = 1'b0, nv_data_bad = 1'b0;
  logic           steady_fault = 1'b0, status_query = 1'b0;
  logic           alarm_reset_cmd = 1'b0, hist_clear = 1'b0, fwd_req = 1'b0;
  lsau_hist_req_s hist_req = '0;
  wire logic      xchg_done, xchg_ok;
  wire logic [3:0] xchg_addr;
  logic [31:0]    status_word;
  logic [7:0]     hist_code, alarm_code;
  logic           status_valid, hist_present, hist_valid, fwd_grant;
  logic           fwd_refuse, alarm_flag_output, link_stop;
  logic           twelve_axis_mode, fault_blink_lamp;
  int             mismatches = 0, n_checks = 0, seed = 32'h6efb, mode = 0;
  int             rsp[12];

  always #20 clk = ~clk;

  // Reference copy of the per-address response bits
  always @(posedge clk)
    if (reset) rsp = '{default: 0};
    else if (xchg_done && xchg_addr < (mode ? 12 : 6)) rsp[xchg_addr] = xchg_ok;

  lsau_top #(.LAMP_ON_CYC(4), .LAMP_OFF_CYC(4), .LAMP_GAP_CYC(10)) dut_u (
    .clk, .reset, .clk_en, .conn_enable, .twelve_axis_pin, .rate_select_switch,
    .overheat_pin, .xchg_done, .xchg_addr, .xchg_ok, .dup_addr_fault,
    .nv_data_bad, .steady_fault, .status_query, .alarm_reset_cmd, .hist_clear,
    .hist_req, .fwd_req, .status_word, .status_valid, .hist_code,
    .hist_present, .hist_valid, .fwd_grant, .fwd_refuse, .alarm_flag_output,
    .alarm_code, .link_stop, .twelve_axis_mode, .fault_blink_lamp);

  lsau_far_model far_u (.clk, .reset, .run, .conn(conn_enable), .bad,
    .done(xchg_done), .addr(xchg_addr), .ok(xchg_ok));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One-cycle command pulse, returns after the taking edge
  task automatic hit(input int w);
    @(posedge clk);
    case (w)
      0: status_query <= 1'b1;
      1: alarm_reset_cmd <= 1'b1;
      2: nv_data_bad <= 1'b1;
      3: dup_addr_fault <= 1'b1;
      4: hist_clear <= 1'b1;
      default: hist_req.rd <= 1'b1;
    endcase
    @(posedge clk);
    status_query <= 1'b0;
    alarm_reset_cmd <= 1'b0;
    nv_data_bad <= 1'b0;
    dup_addr_fault <= 1'b0;
    hist_clear <= 1'b0;
    hist_req.rd <= 1'b0;
    @(negedge clk);
  endtask

  task automatic do_reset(input logic m);
    @(posedge clk);
    reset <= 1'b1;
    twelve_axis_pin <= m;
    mode = m;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_hist(input logic [3:0] ix);
    @(posedge clk);
    hist_req.index <= ix;
    hit(5);
    `CHK("hist valid", 1'b1, hist_valid)
  endtask

  task automatic wait_flag(input logic lvl);
    for (int k = 0; k < 40 && alarm_flag_output !== lvl; k++) @(negedge clk);
    if (alarm_flag_output !== lvl) begin
      mismatches++;
      $display("[ERR] alarm flag exp %0h got %0h", lvl, alarm_flag_output);
      report_and_stop();
    end
  endtask

  task automatic check_alarm(input logic [7:0] code, input int nb,
                             input logic stop);
    int   n;
    logic prv;
    n = 0;
    wait_flag(1'b1);
    `CHK("alarm code", code, alarm_code)
    `CHK("link stop", stop, link_stop)
    prv = fault_blink_lamp;
    for (int c = 0; c < nb * 8 + 5; c++) begin
      @(negedge clk);
      if (fault_blink_lamp && !prv) n++;
      prv = fault_blink_lamp;
    end
    `CHK("blinks", nb, n)
    @(posedge clk);
    fwd_req <= 1'b1;
    @(negedge clk);
    `CHK("fwd grant", !stop, fwd_grant)
    `CHK("fwd refuse", stop, fwd_refuse)
    @(posedge clk);
    fwd_req <= 1'b0;
    rd_hist(4'h0);
    `CHK("hist newest", code, hist_code)
    if (stop) begin
      hit(0);
      `CHK("stopped lower", 12'h000, status_word[11:0])
      hit(1);
      `CHK("flag kept", 1'b1, alarm_flag_output)
    end
  endtask

  task automatic check_status();
    logic [31:0] e;
    e = {4'h0, conn_enable, 16'h0000};
    for (int a = 0; a < 12; a++) e[a] = conn_enable[a] & (rsp[a] != 0);
    hit(0);
    `CHK("status valid", 1'b1, status_valid)
    `CHK("status word", e, status_word)
  endtask

  initial begin
    repeat (4) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      repeat (8) @(negedge clk);
      `CHK("mode", m[0], twelve_axis_mode)
      @(posedge clk);
      conn_enable <= 12'($random(seed)) | 12'h03F;
      bad <= 12'h001 << ({$random(seed)} % 6);
      run <= 1'b1;
      repeat (60) @(posedge clk);
      run <= 1'b0;
      repeat (3) @(negedge clk);
      check_status();
    end
    @(posedge clk) clk_en <= 1'b0;
    hit(0);
    `CHK("frozen query", 1'b0, status_valid)
    @(posedge clk) clk_en <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      overheat_pin <= 1'b1;
      if (i == 0) check_alarm(8'h21, 2, 1'b0);
      else wait_flag(1'b1);
      @(posedge clk);
      overheat_pin <= 1'b0;
      steady_fault <= (i == 0);
      repeat (20) @(negedge clk);
      hit(1);
      `CHK("reset cmd", i == 0, alarm_flag_output)
      @(posedge clk);
      steady_fault <= 1'b0;
      if (i == 0) hit(1);
      `CHK("flag cleared", 1'b0, alarm_flag_output)
    end
    hit(2);
    check_alarm(8'h41, 9, 1'b1);
    rd_hist(4'h1);
    `CHK("hist older", 8'h21, hist_code)
    rd_hist(4'h9);
    `CHK("hist tenth", 1'b1, hist_present)
    rd_hist(4'hA);
    `CHK("hist eleventh", 1'b0, hist_present)
    hit(4);
    rd_hist(4'h0);
    `CHK("hist cleared", 1'b0, hist_present)
    do_reset(1'b0);
    `CHK("power reset", 1'b0, alarm_flag_output)
    hit(3);
    check_alarm(8'h86, 7, 1'b1);
    @(posedge clk) rate_select_switch <= 4'h5;
    do_reset(1'b0);
    check_alarm(8'h83, 7, 1'b1);
    @(posedge clk) rate_select_switch <= 4'h7;
    do_reset(1'b0);
    repeat (8) @(posedge clk);
    conn_enable <= 12'hFFF;
    bad <= 12'hFFF;
    run <= 1'b1;
    check_alarm(8'h84, 7, 1'b1);
    run <= 1'b0;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
